// ===== inc/cmpctl_defs.vh
`ifndef CMPCTL_DEFS_VH
`define CMPCTL_DEFS_VH
// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define CMPCTL_CONFIG_OFS   12'h000
`define CMPCTL_FLAG_OFS     12'h004
`define CMPCTL_ENABLE_OFS   12'h008
`define CMPCTL_INTCTL_OFS   12'h00c
// ----------------------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------------------
`define CMPCTL_MODE_LSB     0
`define CMPCTL_MODE_MSB     2
`define CMPCTL_SWITCH_BIT   3
`define CMPCTL_INVERT_BIT   4
`define CMPCTL_RESULT_BIT   6
`define CMPCTL_CONFIG_RST   8'h00
// Flag, enable and interrupt control bit positions
`define CMPCTL_FLAG_BIT     3
`define CMPCTL_CHGIE_BIT    3
`define CMPCTL_PERIPHERAL_IRQ_ENABLE_BIT     6
`define CMPCTL_GIE_BIT      7
// ----------------------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------------------
`define CMPCTL_MODE_RESET   3'h0
`define CMPCTL_MODE_OUT     3'h1
`define CMPCTL_MODE_NOOUT   3'h2
`define CMPCTL_MODE_REFOUT  3'h3
`define CMPCTL_MODE_REF     3'h4
`define CMPCTL_MODE_MUXOUT  3'h5
`define CMPCTL_MODE_MUX     3'h6
`define CMPCTL_MODE_OFF     3'h7
// Last clock phase index: four system clocks per instruction cycle
`define CMPCTL_PHASES       2'h3
`endif

// ===== hdl/cmpctl_top.v
// How it works
// R1: Raw result high when plus input exceeds minus
// R2: Eight modes by three-bit field, reset 000
// R3: Mode 111 turns comparator off, pins I/O
// R4: Analog pins: input buffer off, read 0
// R5: Output mode pin overrides port function
// R6: Result always readable in config register
// R7: Result drives pin in modes 001,011,101
// R8: Software sets pin direction output first
// R9: Invert bit flips status and pin
// R10: Off modes read 0, or 1 inverted
// R11: Modes 101,110 switch selects minus pin
// R12: Reference latch captures result on config read
// R13: Sample latch each phase one; compare
// R14: Mismatch keeps change flag set
// R15: Config write also ends mismatch
// R16: Flag cleared writing 0; 1 sets it
// R17: Irq needs three enables; flag still sets
// R18: Clear ineffective while mismatch persists
// R19: Change during read may miss flag
// R20: Software disables irq while changing mode
// R21: Software waits 1 us, then clears flags
// R22: Reset returns config to mode 000
// R23: Wake needs change enable and peripheral enable
// R24: Raw result synchronised before sampling latch
`timescale 1ns/10ps
`include "cmpctl_defs.vh"

module cmpctl_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        cmp_raw_result,
  output wire        cmp_enable,
  output wire        inverting_input_pin_sel,
  output wire        internal_voltage_reference_sel,
  output wire        inverting_input_pin_analog,
  output wire        noninverting_input_pin_analog,
  input  wire        port_out_data,
  input  wire        port_pin_direction_bit,
  output wire        result_pin_out,
  output wire        result_pin_oe,
  output wire        result_pin_override,
  input  wire [2:0]  port_pin_in,
  output wire [2:0]  port_pin_read,
  output wire        irq,
  output wire        wake
);

  // --------------------------------------------------------------------------
  // Registers and state
  // --------------------------------------------------------------------------
  reg  [2:0] mode_reg;
  reg        input_switch_select_reg;
  reg        output_invert_reg;
  reg        flag_reg;
  reg        chg_ie_reg;
  reg        peripheral_irq_enable_reg;
  reg        gie_reg;
  reg        sync1_reg;
  reg        sync2_reg;
  reg        ref_latch_reg;
  reg        sample_latch_reg;
  reg        mismatch_prev_reg;
  reg  [1:0] phase_reg;
  reg  [2:0] pin_sync1_reg;
  reg  [2:0] pin_sync2_reg;

  wire       comp_on;
  wire       comparator_result;
  wire       mismatch;
  wire       wr_acc;
  wire       rd_acc;
  wire       cfg_sel;
  wire       flg_sel;
  wire       en_sel;
  wire       ic_sel;
  wire       phase_one;
  wire       flag_set_evt;
  reg  [2:0] analog_mask;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  // Zero wait states; unmapped offsets read zero and report an error
  assign pready  = 1'b1;
  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & penable & ~pwrite;
  assign cfg_sel = (paddr == `CMPCTL_CONFIG_OFS);
  assign flg_sel = (paddr == `CMPCTL_FLAG_OFS);
  assign en_sel  = (paddr == `CMPCTL_ENABLE_OFS);
  assign ic_sel  = (paddr == `CMPCTL_INTCTL_OFS);
  assign pslverr = psel & penable & ~(cfg_sel | flg_sel | en_sel | ic_sel);

  // --------------------------------------------------------------------------
  // Mode decode
  // --------------------------------------------------------------------------
  // Comparator powered except in reset and off modes
  assign comp_on = (mode_reg != `CMPCTL_MODE_RESET) && (mode_reg != `CMPCTL_MODE_OFF); // R2 R3
  assign cmp_enable = comp_on;
  // Switch only matters in the multiplexed modes; elsewhere the first pin feeds
  assign inverting_input_pin_sel = ((mode_reg == `CMPCTL_MODE_MUXOUT) ||
                                    (mode_reg == `CMPCTL_MODE_MUX)) & input_switch_select_reg; // R11
  assign internal_voltage_reference_sel = (mode_reg == `CMPCTL_MODE_REFOUT) ||
                                          (mode_reg == `CMPCTL_MODE_REF) ||
                                          (mode_reg == `CMPCTL_MODE_MUXOUT) ||
                                          (mode_reg == `CMPCTL_MODE_MUX);

  // Per-pin analog assignment: bit0 minus pin, bit1 plus pin, bit2 result pin
  always @* begin
    case (mode_reg)
      `CMPCTL_MODE_RESET:  analog_mask = 3'h3; // R22
      `CMPCTL_MODE_OUT:    analog_mask = 3'h3;
      `CMPCTL_MODE_NOOUT:  analog_mask = 3'h3;
      `CMPCTL_MODE_REFOUT: analog_mask = 3'h1;
      `CMPCTL_MODE_REF:    analog_mask = 3'h1;
      `CMPCTL_MODE_MUXOUT: analog_mask = 3'h3; // R11
      `CMPCTL_MODE_MUX:    analog_mask = 3'h3; // R11
      `CMPCTL_MODE_OFF:    analog_mask = 3'h0; // R3
      default:             analog_mask = 3'h0;
    endcase
  end
  assign inverting_input_pin_analog    = analog_mask[0];
  assign noninverting_input_pin_analog = analog_mask[1];

  // --------------------------------------------------------------------------
  // Result path
  // --------------------------------------------------------------------------
  // Analog result is asynchronous; two flops before any logic looks at it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= cmp_raw_result; // R24 R1
      sync2_reg <= sync1_reg;      // R24
    end
  end

  // Off modes force zero before inversion, so off reads the invert bit
  assign comparator_result = (sync2_reg & comp_on) ^ output_invert_reg; // R9 R10

  // Result pin overrides port only in the output modes
  assign result_pin_override = (mode_reg == `CMPCTL_MODE_OUT) ||
                               (mode_reg == `CMPCTL_MODE_REFOUT) ||
                               (mode_reg == `CMPCTL_MODE_MUXOUT); // R7
  // Direction bit still gates the driver; software must make it an output
  assign result_pin_oe  = ~port_pin_direction_bit; // R8
  assign result_pin_out = result_pin_override ? comparator_result : port_out_data; // R5 R9

  // Pin inputs synchronised; analog pins read zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync1_reg <= 3'h0;
      pin_sync2_reg <= 3'h0;
    end else begin
      pin_sync1_reg <= port_pin_in;
      pin_sync2_reg <= pin_sync1_reg;
    end
  end
  assign port_pin_read = pin_sync2_reg & ~analog_mask; // R4

  // --------------------------------------------------------------------------
  // Clock phase divider
  // --------------------------------------------------------------------------
  // Phase one pulses once every four clocks, as the instruction cycle does
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end
  assign phase_one = (phase_reg == 2'h0);

  // --------------------------------------------------------------------------
  // Mismatch latches
  // --------------------------------------------------------------------------
  // Reference latch updates on any config access, write included
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_latch_reg    <= 1'b0;
      sample_latch_reg <= 1'b0;
    end else begin
      if ((rd_acc | wr_acc) & cfg_sel) begin
        ref_latch_reg <= comparator_result; // R12 R15
      end
      if (phase_one) begin
        sample_latch_reg <= comparator_result; // R13
      end
    end
  end

  // A change landing in the access cycle is absorbed by the reference latch
  assign mismatch = sample_latch_reg ^ ref_latch_reg; // R13 R19

  // --------------------------------------------------------------------------
  // Change flag
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mismatch_prev_reg <= 1'b0;
    end else begin
      mismatch_prev_reg <= mismatch;
    end
  end
  assign flag_set_evt = mismatch & ~mismatch_prev_reg;

  // Set beats clear; a standing mismatch reasserts the flag every cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= 1'b0;
    end else if (flag_set_evt | mismatch) begin
      flag_reg <= 1'b1; // R14 R18
    end else if (wr_acc & flg_sel) begin
      flag_reg <= pwdata[`CMPCTL_FLAG_BIT]; // R16
    end
  end

  // --------------------------------------------------------------------------
  // Configuration and enable registers
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg                <= `CMPCTL_MODE_RESET; // R22 R2
      input_switch_select_reg <= 1'b0;
      output_invert_reg       <= 1'b0;
      chg_ie_reg              <= 1'b0;
      peripheral_irq_enable_reg                <= 1'b0;
      gie_reg                 <= 1'b0;
    end else begin
      if (wr_acc & cfg_sel) begin
        mode_reg                <= pwdata[`CMPCTL_MODE_MSB:`CMPCTL_MODE_LSB]; // R2
        input_switch_select_reg <= pwdata[`CMPCTL_SWITCH_BIT];
        output_invert_reg       <= pwdata[`CMPCTL_INVERT_BIT];
      end
      if (wr_acc & en_sel) begin
        chg_ie_reg <= pwdata[`CMPCTL_CHGIE_BIT];
      end
      if (wr_acc & ic_sel) begin
        peripheral_irq_enable_reg <= pwdata[`CMPCTL_PERIPHERAL_IRQ_ENABLE_BIT];
        gie_reg  <= pwdata[`CMPCTL_GIE_BIT];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt and wake
  // --------------------------------------------------------------------------
  assign irq  = flag_reg & chg_ie_reg & peripheral_irq_enable_reg & gie_reg; // R17
  assign wake = flag_reg & chg_ie_reg & peripheral_irq_enable_reg;           // R23

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  // Read data registered at the access edge would lag; drive combinationally
  always @* begin
    prdata = 32'h0000_0000;
    if (cfg_sel) begin
      prdata[`CMPCTL_MODE_MSB:`CMPCTL_MODE_LSB] = mode_reg;
      prdata[`CMPCTL_SWITCH_BIT] = input_switch_select_reg;
      prdata[`CMPCTL_INVERT_BIT] = output_invert_reg;
      prdata[`CMPCTL_RESULT_BIT] = comparator_result; // R6
    end else if (flg_sel) begin
      prdata[`CMPCTL_FLAG_BIT] = flag_reg;
    end else if (en_sel) begin
      prdata[`CMPCTL_CHGIE_BIT] = chg_ie_reg;
    end else if (ic_sel) begin
      prdata[`CMPCTL_PERIPHERAL_IRQ_ENABLE_BIT] = peripheral_irq_enable_reg;
      prdata[`CMPCTL_GIE_BIT]  = gie_reg;
    end
  end

endmodule // cmpctl_top

// ===== dv/cmpctl_analog.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Analog comparator core stand-in, levels in millivolts from the bench
// ----------------------------------------------------------------------------
module cmpctl_analog (
  input  wire        pclk,
  input  wire        cmp_enable,
  input  wire        inverting_input_pin_sel,
  input  wire [15:0] plus_mv,
  input  wire [15:0] minus_a_mv,
  input  wire [15:0] minus_b_mv,
  output logic       cmp_raw_result
);
  logic junk = 1'h0;
  // Powered down, the core output means nothing, so it wanders every cycle
  always @(posedge pclk) junk <= ~junk;
  // High when the plus level exceeds the selected minus level
  always @* begin
    if (!cmp_enable) cmp_raw_result = junk;
    else cmp_raw_result = plus_mv > (inverting_input_pin_sel ? minus_b_mv : minus_a_mv);
  end
endmodule // cmpctl_analog

// ===== dv/cmpctl_sva.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Pin and mode checks on the top ports
// ----------------------------------------------------------------------------
module cmpctl_sva (
  input wire       pclk,
  input wire       presetn,
  input wire       cmp_enable,
  input wire       inverting_input_pin_sel,
  input wire       internal_voltage_reference_sel,
  input wire       inverting_input_pin_analog,
  input wire       noninverting_input_pin_analog,
  input wire       port_out_data,
  input wire       port_pin_direction_bit,
  input wire       result_pin_out,
  input wire       result_pin_oe,
  input wire       result_pin_override,
  input wire [2:0] port_pin_read,
  input wire       irq,
  input wire       wake
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Interrupt needs a superset of the wake enables
  irq_gate_a: assert property (irq |-> wake) else $error("irq without wake");
  drive_mode_a: assert property (result_pin_override |-> cmp_enable) else $error("pin driven while off");
  port_pass_a: assert property (!result_pin_override |-> result_pin_out == port_out_data)
    else $error("port data lost");
  pin_dir_a: assert property (result_pin_oe != port_pin_direction_bit) else $error("pin enable wrong");
  minus_read_a: assert property (inverting_input_pin_analog |-> !port_pin_read[0]) else $error("minus read");
  plus_read_a: assert property (noninverting_input_pin_analog |-> !port_pin_read[1]) else $error("plus read");
  switch_mode_a: assert property (inverting_input_pin_sel |-> cmp_enable && internal_voltage_reference_sel)
    else $error("switch outside its modes");
  off_pins_a: assert property (!cmp_enable |-> !inverting_input_pin_sel && !result_pin_override)
    else $error("off mode drives");
  // First edge after release must show the reset mode with both input pins analog
  reset_mode_a: assert property ($rose(presetn) |-> !cmp_enable && inverting_input_pin_analog
    && noninverting_input_pin_analog) else $error("not in reset mode");
endmodule // cmpctl_sva

// ===== dv/tb.sv
`timescale 1ns/10ps
`include "cmpctl_defs.vh"
module tb;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] plus_mv = 16'h01f4, minus_a_mv = 16'h012c, minus_b_mv = 16'h02bc;
  logic [7:0]  lfsr = 8'h12;
  logic [5:0]  i;
  logic [2:0]  pin_in = 3'h0, m, mask;
  logic        odat = 1'h0, dir = 1'h1, sw, inv, res, on, ovr;
  wire  [31:0] prdata;
  wire  [2:0]  pin_rd;
  wire         pready, pslverr, raw, cen, isel, vsel, ana_m, ana_p, pout, poe, povr, irq, wake;
  logic [31:0] exp_q[$];
  int          num_errors = 0, n_tests = 0;
  // 25 MHz bus clock
  always #20 pclk = ~pclk;
  cmpctl_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_raw_result(raw), .cmp_enable(cen), .inverting_input_pin_sel(isel),
    .internal_voltage_reference_sel(vsel), .inverting_input_pin_analog(ana_m),
    .noninverting_input_pin_analog(ana_p), .port_out_data(odat), .port_pin_direction_bit(dir),
    .result_pin_out(pout), .result_pin_oe(poe), .result_pin_override(povr), .port_pin_in(pin_in),
    .port_pin_read(pin_rd), .irq(irq), .wake(wake));
  cmpctl_analog u_core (.pclk(pclk), .cmp_enable(cen), .inverting_input_pin_sel(isel), .plus_mv(plus_mv),
    .minus_a_mv(minus_a_mv), .minus_b_mv(minus_b_mv), .cmp_raw_result(raw));
  // ----------------------------------------------------------------------------
  // Bus driver, scoreboard and verdict
  // ----------------------------------------------------------------------------
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Entered at a rising edge; the idle edge at the end keeps psel from two writes in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) exp_q.push_back(e);
    @(posedge pclk) penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  // Read data is judged where the access phase completes
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'h1 && !pwrite) check(prdata, exp_q.pop_front());
    // Unmapped offsets must flag an error in the access cycle, mapped ones never
    if (psel && penable && pready === 1'h1)
      check(pslverr, !(paddr inside {`CMPCTL_CONFIG_OFS, `CMPCTL_FLAG_OFS, `CMPCTL_ENABLE_OFS, `CMPCTL_INTCTL_OFS}));
  end
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Whole run is near 18 us; a hang is cut well after that
  initial begin
    #200us;
    num_errors++;
    $display("[ERR] %0t run timed out", $time);
    results();
  end
  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(0, `CMPCTL_CONFIG_OFS, 0, 32'h0);
    apb(0, `CMPCTL_FLAG_OFS, 0, 32'h0);
    apb(0, `CMPCTL_INTCTL_OFS, 0, 32'h0);
    apb(0, 12'h010, 0, 32'h0);
    $display("reset values done");
    // Every mode, switch and polarity with random pins and port data
    for (i = 0; i < 32; i++) begin
      {inv, sw, m} = i[4:0];
      lfsr = lfsr_next(lfsr);
      ovr = (m == 1 || m == 3 || m == 5);
      on = (m != 0 && m != 7);
      pin_in <= lfsr[2:0];
      odat <= lfsr[3];
      dir <= !ovr;
      apb(1, `CMPCTL_CONFIG_OFS, {27'h0, inv, sw, m}, 0);
      repeat (4) @(posedge pclk);
      res = on ? ((plus_mv > ((sw && (m == 5 || m == 6)) ? minus_b_mv : minus_a_mv)) ^ inv) : inv;
      mask = {1'h0, m inside {0, 1, 2, 5, 6}, m != 7};
      apb(0, `CMPCTL_CONFIG_OFS, 0, {25'h0, res, 1'h0, inv, sw, m});
      check(cen, on);
      check(povr, ovr);
      check(pout, ovr ? res : lfsr[3]);
      check(pin_rd, lfsr[2:0] & ~mask);
      check(isel, sw && (m == 5 || m == 6));
    end
    $display("mode table done");
    // Change detection; enables stay clear through the mode change
    apb(1, `CMPCTL_CONFIG_OFS, 32'h2, 0);
    repeat (25) @(posedge pclk);
    apb(0, `CMPCTL_CONFIG_OFS, 0, 32'h42);
    apb(1, `CMPCTL_FLAG_OFS, 0, 0);
    apb(0, `CMPCTL_FLAG_OFS, 0, 32'h0);
    apb(1, `CMPCTL_ENABLE_OFS, 32'h8, 0);
    apb(1, `CMPCTL_INTCTL_OFS, 32'h40, 0);
    plus_mv <= 16'h00c8;
    repeat (10) @(posedge pclk);
    apb(0, `CMPCTL_FLAG_OFS, 0, 32'h8);
    check(wake, 1'h1);
    check(irq, 1'h0);
    apb(1, `CMPCTL_FLAG_OFS, 0, 0);
    apb(0, `CMPCTL_FLAG_OFS, 0, 32'h8);
    apb(1, `CMPCTL_INTCTL_OFS, 32'hc0, 0);
    check(irq, 1'h1);
    apb(0, `CMPCTL_CONFIG_OFS, 0, 32'h2);
    apb(1, `CMPCTL_FLAG_OFS, 0, 0);
    apb(0, `CMPCTL_FLAG_OFS, 0, 32'h0);
    check(irq, 1'h0);
    plus_mv <= 16'h01f4;
    repeat (10) @(posedge pclk);
    apb(1, `CMPCTL_CONFIG_OFS, 32'h2, 0);
    apb(1, `CMPCTL_FLAG_OFS, 0, 0);
    apb(0, `CMPCTL_FLAG_OFS, 0, 32'h0);
    apb(1, `CMPCTL_FLAG_OFS, 32'h8, 0);
    apb(0, `CMPCTL_FLAG_OFS, 0, 32'h8);
    check(irq, 1'h1);
    $display("change detect done");
    results();
  end
endmodule // tb
bind cmpctl_top cmpctl_sva u_sva (.pclk(pclk), .presetn(presetn), .cmp_enable(cmp_enable),
  .inverting_input_pin_sel(inverting_input_pin_sel), .internal_voltage_reference_sel(internal_voltage_reference_sel),
  .inverting_input_pin_analog(inverting_input_pin_analog), .noninverting_input_pin_analog(noninverting_input_pin_analog),
  .port_out_data(port_out_data), .port_pin_direction_bit(port_pin_direction_bit), .result_pin_out(result_pin_out),
  .result_pin_oe(result_pin_oe), .result_pin_override(result_pin_override), .port_pin_read(port_pin_read),
  .irq(irq), .wake(wake));
